// >>> core/supply_monitor_fault_irq_ctrl.sv
// supply monitor, thermal shutdown, buck channel enable/delay/soft-start and fault interrupts
// assumes asynchronous analog comparator inputs and an AHB-Lite master on hclk
//
// Functional notes
// RULE1 - four-bit threshold code drives comparator select
// RULE2 - threshold resets to 3.0 V code
// RULE3 - supply-low status follows comparator
// RULE4 - interrupt mode flags unmasked supply drop
// RULE5 - supply-low clears after recovery and read
// RULE6 - shutdown mode drops every channel immediately
// RULE7 - over-temperature disables and blocks all enables
// RULE8 - enabled channel ramps over 400 us
// RULE9 - on bit edges enable or disable
// RULE10 - host toggles on bit to switch
// RULE11 - three-bit turn-on delay per channel
// RULE12 - delay codes mean 0 to 128 ms
// RULE13 - mode bit picks light-load or forced PWM
// RULE14 - power-good bit mirrors its comparator
// RULE15 - fault interrupt held until power-good read
// RULE16 - interrupt output active-low open-drain
// RULE17 - interrupt sources masked after reset
// RULE18 - faults latch on power-good fall, ORed
// RULE19 - asynchronous inputs synchronised before use
`default_nettype none
module supply_monitor_fault_irq_ctrl #(
    parameter int n_chan = 3,
    parameter int soft_start_cycles = supmon_pkg::soft_start_cyc,
    parameter int ms_cycles = supmon_pkg::ms_cyc
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog comparators, asynchronous
    input wire logic supply_below,
    input wire logic [n_chan-1:0] power_good,
    input wire logic over_temp,
    // analog controls
    output logic [3:0] undervoltage_threshold_sel,
    output logic [n_chan-1:0] chan_enable,
    output logic [n_chan-1:0] chan_soft_start,
    output logic [n_chan-1:0] chan_forced_pwm,
    // open-drain interrupt: irq_out_n output, oe high while pulling low
    output logic irq_out_n,
    output logic irq_out_oe
);
    typedef enum logic [1:0] {ch_off = 2'b00, ch_wait = 2'b01, ch_ramp = 2'b11, ch_on = 2'b10} ch_state_t;

    // synchronisers: three stages, change taken when stages two and three agree
    logic [n_chan+1:0] sync1_r, sync2_r, sync3_r, clean_r;
    logic [n_chan+1:0] raw_in;
    assign raw_in = {over_temp, power_good, supply_below};

    // three-stage capture of comparator levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= raw_in; // [RULE19]
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // cleaned level updates only on agreement, filtering one-cycle glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clean_r <= '0;
        end else begin
            for (int i = 0; i < n_chan + 2; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    clean_r[i] <= sync3_r[i]; // [RULE19]
                end
            end
        end
    end

    logic low_s, temp_s;
    logic [n_chan-1:0] good_s;
    assign low_s = clean_r[0];
    assign good_s = clean_r[n_chan:1];
    assign temp_s = clean_r[n_chan+1];

    // bus address phase capture
    logic wr_pend_r, rd_pend_r;
    logic [7:0] addr_r;
    logic take;
    assign take = hsel && hready && htrans[1];

    // one-wait-free slave: data phase follows the address phase directly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take && hwrite;
            rd_pend_r <= take && !hwrite;
            if (take) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    logic wr_ctrl, wr_cfg, wr_istat, wr_imask, rd_status;
    assign wr_ctrl = wr_pend_r && addr_r == supmon_pkg::off_ctrl;
    assign wr_cfg = wr_pend_r && addr_r == supmon_pkg::off_chan_cfg;
    assign wr_istat = wr_pend_r && addr_r == supmon_pkg::off_irq_stat;
    assign wr_imask = wr_pend_r && addr_r == supmon_pkg::off_irq_mask;
    assign rd_status = rd_pend_r && addr_r == supmon_pkg::off_status;

    // control register: threshold and response mode
    logic resp_irq_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            undervoltage_threshold_sel <= supmon_pkg::thr_reset; // [RULE2]
            resp_irq_r <= supmon_pkg::resp_reset;
        end else if (wr_ctrl) begin
            undervoltage_threshold_sel <= hwdata[supmon_pkg::ctrl_thr_lsb +: 4]; // [RULE1]
            resp_irq_r <= hwdata[supmon_pkg::ctrl_resp_bit];
        end
    end

    // channel config: on bit, mode bit, delay code
    logic [n_chan-1:0] on_r, on_prev_r;
    logic [n_chan*3-1:0] dly_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_r <= '0;
            on_prev_r <= '0;
            chan_forced_pwm <= '0;
            dly_r <= '0;
        end else begin
            on_prev_r <= on_r;
            if (wr_cfg) begin
                for (int i = 0; i < n_chan; i++) begin
                    on_r[i] <= hwdata[i*supmon_pkg::cfg_stride + supmon_pkg::cfg_on_bit];
                    chan_forced_pwm[i] <= hwdata[i*supmon_pkg::cfg_stride + supmon_pkg::cfg_mode_bit]; // [RULE13]
                    dly_r[i*3 +: 3] <= hwdata[i*supmon_pkg::cfg_stride + supmon_pkg::cfg_dly_lsb +: 3]; // [RULE11]
                end
            end
        end
    end

    // global kill: over-temperature, or supply drop in shutdown mode
    logic kill;
    assign kill = temp_s || (low_s && !resp_irq_r); // [RULE6] [RULE7]

    // millisecond tick shared by all delay counters
    logic [$clog2(ms_cycles)-1:0] ms_cnt_r;
    logic ms_tick;
    assign ms_tick = ms_cnt_r == ($clog2(ms_cycles))'(ms_cycles - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
        end
    end

    // per-channel sequencer: edge detect, delay, soft-start ramp
    // unpacked so that each channel's process owns its own element
    ch_state_t st_r [n_chan];
    genvar g;
    generate
        for (g = 0; g < n_chan; g++) begin : g_chan
            logic rise, fall;
            logic [7:0] dly_ms, ms_left_r;
            logic [$clog2(soft_start_cycles+1)-1:0] ss_cnt_r;
            assign rise = on_r[g] && !on_prev_r[g]; // [RULE9]
            assign fall = !on_r[g] && on_prev_r[g]; // [RULE9]
            // code 0 means no wait, otherwise 2^code ms
            assign dly_ms = (dly_r[g*3 +: 3] == 3'd0) ? 8'd0 : 8'd1 << dly_r[g*3 +: 3]; // [RULE12]
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    st_r[g] <= ch_off;
                    ms_left_r <= 8'h00;
                    ss_cnt_r <= '0;
                end else if (kill || fall) begin
                    st_r[g] <= ch_off; // [RULE6] [RULE7]
                end else begin
                    case (st_r[g])
                        ch_off: begin
                            if (rise) begin
                                // ms counter phase makes the first ms short by up to ms_cycles - 1 cycles
                                st_r[g] <= ch_wait; // [RULE11]
                                ms_left_r <= dly_ms;
                            end
                        end
                        ch_wait: begin
                            if (ms_left_r == 8'h00) begin
                                st_r[g] <= ch_ramp;
                                ss_cnt_r <= '0;
                            end else if (ms_tick) begin
                                ms_left_r <= ms_left_r - 8'd1;
                            end
                        end
                        ch_ramp: begin
                            if (ss_cnt_r == ($clog2(soft_start_cycles+1))'(soft_start_cycles - 1)) begin
                                st_r[g] <= ch_on; // [RULE8]
                            end else begin
                                ss_cnt_r <= ss_cnt_r + 1'b1;
                            end
                        end
                        ch_on: st_r[g] <= ch_on;
                        default: st_r[g] <= ch_off;
                    endcase
                end
            end
        end
    endgenerate

    // analog drive straight from flops; kill drops them in the same edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_enable <= '0;
            chan_soft_start <= '0;
        end else begin
            for (int i = 0; i < n_chan; i++) begin
                chan_enable[i] <= !kill && (st_r[i] == ch_ramp || st_r[i] == ch_on); // [RULE7]
                chan_soft_start[i] <= !kill && st_r[i] == ch_ramp; // [RULE8]
            end
        end
    end

    // sticky interrupt status and mask
    logic [n_chan:0] istat_r, imask_r;
    logic [n_chan-1:0] good_d_r;
    logic low_seen_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // matches the cleaned level after reset, so no false fault edge follows reset
            good_d_r <= '0;
            low_seen_r <= 1'b0;
        end else begin
            good_d_r <= good_s;
            // a status read while recovered arms the supply-low clear
            if (low_s) begin
                low_seen_r <= 1'b0;
            end else if (rd_status) begin
                low_seen_r <= 1'b1;
            end
        end
    end

    logic [n_chan:0] set_ev, clr_ev;
    always_comb begin
        set_ev = '0;
        clr_ev = '0;
        set_ev[0] = low_s && resp_irq_r; // [RULE4]
        clr_ev[0] = !low_s && (rd_status || low_seen_r); // [RULE5]
        for (int i = 0; i < n_chan; i++) begin
            set_ev[i+1] = good_d_r[i] && !good_s[i]; // [RULE18]
            clr_ev[i+1] = rd_status; // [RULE15]
        end
        if (wr_istat) begin
            clr_ev = clr_ev | hwdata[n_chan:0];
        end
    end

    // set wins over any clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_r <= '0;
        end else begin
            istat_r <= set_ev | (istat_r & ~clr_ev);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imask_r <= supmon_pkg::mask_reset; // [RULE17]
        end else if (wr_imask) begin
            imask_r <= hwdata[n_chan:0];
        end
    end

    // open-drain drive: pull low while any unmasked source pends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out_n <= 1'b1;
            irq_out_oe <= 1'b0;
        end else begin
            irq_out_n <= ~|(istat_r & imask_r); // [RULE16] [RULE18]
            irq_out_oe <= |(istat_r & imask_r); // [RULE16]
        end
    end

    // read mux registered in the address phase
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            supmon_pkg::off_ctrl: begin
                rd_mux[supmon_pkg::ctrl_thr_lsb +: 4] = undervoltage_threshold_sel;
                rd_mux[supmon_pkg::ctrl_resp_bit] = resp_irq_r;
            end
            supmon_pkg::off_status: begin
                rd_mux[supmon_pkg::st_low_bit] = low_s; // [RULE3]
                rd_mux[supmon_pkg::st_good_lsb +: 3] = good_s; // [RULE14]
                rd_mux[supmon_pkg::st_temp_bit] = temp_s;
                rd_mux[supmon_pkg::st_en_lsb +: 3] = chan_enable;
                rd_mux[supmon_pkg::st_ss_lsb +: 3] = chan_soft_start;
            end
            supmon_pkg::off_chan_cfg: begin
                for (int i = 0; i < n_chan; i++) begin
                    rd_mux[i*supmon_pkg::cfg_stride + supmon_pkg::cfg_on_bit] = on_r[i];
                    rd_mux[i*supmon_pkg::cfg_stride + supmon_pkg::cfg_mode_bit] = chan_forced_pwm[i];
                    rd_mux[i*supmon_pkg::cfg_stride + supmon_pkg::cfg_dly_lsb +: 3] = dly_r[i*3 +: 3];
                end
            end
            supmon_pkg::off_irq_stat: rd_mux[n_chan:0] = istat_r;
            supmon_pkg::off_irq_mask: rd_mux[n_chan:0] = imask_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1; // never stretches
            hresp <= 1'b0;     // always OKAY
        end
    end

    // assertions
    property p_kill_drops;
        @(posedge hclk) disable iff (!hresetn) kill |=> chan_enable == '0;
    endproperty
    a_kill_drops: assert property (p_kill_drops) else $error("channel left on during kill"); // [RULE7]

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn) (|(istat_r & imask_r)) |=> !irq_out_n && irq_out_oe;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not driven low"); // [RULE16]

    property p_low_sets;
        @(posedge hclk) disable iff (!hresetn) (low_s && resp_irq_r) |=> istat_r[0];
    endproperty
    a_low_sets: assert property (p_low_sets) else $error("supply-low event lost"); // [RULE4]

    property p_low_holds;
        @(posedge hclk) disable iff (!hresetn) (istat_r[0] && low_s && !wr_istat) |=> istat_r[0];
    endproperty
    a_low_holds: assert property (p_low_holds) else $error("supply-low cleared while low"); // [RULE5]

    property p_fault_latch;
        @(posedge hclk) disable iff (!hresetn) $fell(good_s[0]) |=> istat_r[1];
    endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("fault not latched"); // [RULE18]

    sequence s_rise0;
        !on_prev_r[0] && on_r[0] && st_r[0] == ch_off && !kill && dly_r[2:0] == 3'd0;
    endsequence
    property p_zero_delay;
        @(posedge hclk) disable iff (!hresetn) s_rise0 ##1 (!kill && on_r[0]) [*2] |=> chan_enable[0];
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay start late"); // [RULE11]

    property p_shut_mode;
        @(posedge hclk) disable iff (!hresetn) (low_s && !resp_irq_r) |=> chan_enable == '0 && !istat_r[0];
    endproperty
    a_shut_mode: assert property (p_shut_mode) else $error("shutdown mode misbehaved"); // [RULE6]

    property p_mask_reset;
        @(posedge hclk) $rose(hresetn) |-> imask_r == '0 && undervoltage_threshold_sel == 4'h7;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("bad reset values"); // [RULE17]
endmodule // supply_monitor_fault_irq_ctrl
`default_nettype wire

// >>> include/supmon_pkg.sv
// package: register map, field layout, reset values and timing counts of the supply monitor block
// assumes a 50 MHz hclk and an AHB-Lite slave with 32-bit data
`default_nettype none
package supmon_pkg;
    // register byte offsets
    localparam logic [7:0] off_ctrl = 8'h00;       // threshold, response mode
    localparam logic [7:0] off_status = 8'h04;     // live comparator states
    localparam logic [7:0] off_chan_cfg = 8'h08;   // on, mode, delay per channel
    localparam logic [7:0] off_irq_stat = 8'h0C;   // sticky events, write one to clear
    localparam logic [7:0] off_irq_mask = 8'h10;   // one enables a source
    // ctrl fields
    localparam int ctrl_thr_lsb = 0;
    localparam int ctrl_resp_bit = 4;
    localparam logic [3:0] thr_reset = 4'h7;      // 3.0 V falling threshold
    localparam logic resp_reset = 1'b1;           // interrupt response
    // status fields
    localparam int st_low_bit = 0;
    localparam int st_good_lsb = 1;
    localparam int st_temp_bit = 4;
    localparam int st_en_lsb = 5;
    localparam int st_ss_lsb = 8;
    // channel config: 5 bits per channel
    localparam int cfg_stride = 5;
    localparam int cfg_on_bit = 0;
    localparam int cfg_mode_bit = 1;
    localparam int cfg_dly_lsb = 2;
    // irq bits: 0 supply low, 1..3 channel faults
    localparam int irq_low_bit = 0;
    localparam int irq_flt_lsb = 1;
    localparam logic [3:0] mask_reset = 4'h0;     // all masked after reset
    // timing
    localparam int clk_mhz = 50;
    localparam int soft_start_us = 400;
    localparam int soft_start_cyc = soft_start_us * clk_mhz;
    localparam int ms_cyc = 1000 * clk_mhz;       // cycles in one millisecond
endpackage
`default_nettype wire

// >>> bench/analog_plant.sv
// partner model: the power-good comparators and the pulled-up interrupt wire
// assumes the registered channel outputs of the supply monitor
`default_nettype none
module analog_plant (
    // channel state from the monitor
    input wire logic [2:0] chan_enable,
    input wire logic [2:0] chan_soft_start,
    // faults commanded by the bench
    input wire logic [2:0] fault_inj,
    // open-drain interrupt pin
    input wire logic irq_out_n,
    input wire logic irq_out_oe,
    // comparator results and resolved wire
    output logic [2:0] power_good,
    output logic irq_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // output counts as good only once the ramp is over; an off channel reads low
    assign power_good = chan_enable & ~chan_soft_start & ~fault_inj;
    // pull-up wins whenever nobody drives the pin
    assign irq_wire = irq_out_oe ? irq_out_n : 1'b1;
endmodule // analog_plant
`default_nettype wire

// >>> bench/supply_monitor_fault_irq_ctrl_tb.sv
// testbench: register access, supply drop, channel start-up, faults and shutdown paths
// assumes a zero-wait slave and shortened ms and ramp counts
`default_nettype none
module supply_monitor_fault_irq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset and bus
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    // analog side
    logic supply_below;
    logic over_temp;
    logic [2:0] fault_inj;
    logic [2:0] power_good;
    logic [3:0] undervoltage_threshold_sel;
    logic [2:0] chan_enable;
    logic [2:0] chan_soft_start;
    logic [2:0] chan_forced_pwm;
    logic irq_out_n;
    logic irq_out_oe;
    logic irq_wire;
    // shadow of the channel config word
    logic [14:0] cfg_sh;
    int mismatches = 0;
    int n_checks = 0;

    always #10 hclk = ~hclk;

    // short counts keep the 128 ms code within a few thousand cycles
    supply_monitor_fault_irq_ctrl #(.n_chan(3), .soft_start_cycles(20), .ms_cycles(10)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .supply_below(supply_below), .power_good(power_good),
        .over_temp(over_temp), .undervoltage_threshold_sel(undervoltage_threshold_sel),
        .chan_enable(chan_enable), .chan_soft_start(chan_soft_start), .chan_forced_pwm(chan_forced_pwm),
        .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe));

    analog_plant plant (.chan_enable(chan_enable), .chan_soft_start(chan_soft_start),
        .fault_inj(fault_inj), .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe),
        .power_good(power_good), .irq_wire(irq_wire));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // one single transfer; the address phase is held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0000_0000, q);
    endtask

    task automatic wr_cfg();
        wr(supmon_pkg::off_chan_cfg, {17'h0_0000, cfg_sh});
    endtask

    // reset values, an unmapped read and the idle pin
    task automatic t_reset();
        logic [31:0] q;
        rd(supmon_pkg::off_ctrl, q);
        check(q, 32'h0000_0017);
        check(undervoltage_threshold_sel, 4'h7);
        rd(supmon_pkg::off_irq_mask, q);
        check(q, 32'h0000_0000);
        rd(8'h20, q);
        check(q, 32'h0000_0000);
        check(hresp, 1'b0);
        // no fault may be latched just because reset released
        rd(supmon_pkg::off_irq_stat, q);
        check(q, 32'h0000_0000);
        check(irq_wire, 1'b1);
    endtask

    // every threshold code reaches the comparator
    task automatic t_thresh();
        for (int c = 0; c < 16; c++) begin
            wr(supmon_pkg::off_ctrl, 32'h0000_0010 | c);
            cyc(1);
            check(undervoltage_threshold_sel, c[3:0]);
        end
        wr(supmon_pkg::off_ctrl, 32'h0000_0017);
    endtask

    // supply drop in interrupt mode: masked, unmasked, recovery without read, then read
    task automatic t_low_irq();
        logic [31:0] q;
        supply_below <= 1'b1;
        cyc(8);
        check(irq_wire, 1'b1);
        wr(supmon_pkg::off_irq_mask, 32'h0000_0001);
        cyc(2);
        check(irq_wire, 1'b0);
        supply_below <= 1'b0;
        cyc(10);
        check(irq_wire, 1'b0);
        rd(supmon_pkg::off_status, q);
        check(q[0], 1'b0);
        cyc(3);
        check(irq_wire, 1'b1);
    endtask

    // toggle a channel on with a delay code and time the delay and the ramp
    task automatic t_chan(input int ch, input logic [2:0] code);
        int n;
        int t;
        cfg_sh[5*ch +: 5] = {code, ch[0], 1'b0};
        wr_cfg();
        cfg_sh[5*ch] = 1'b1;
        wr_cfg();
        n = 0;
        while (chan_soft_start[ch] !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        // the first ms tick may come early, so allow one ms short
        t = (code == 3'h0) ? 0 : (1 << code) * 10;
        check(n >= t - 10 && n <= t + 6, 1);
        check(chan_forced_pwm[ch], ch[0]);
        n = 0;
        while (chan_soft_start[ch] === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        check(n >= 19 && n <= 21, 1);
        check(chan_enable[ch], 1'b1);
        wr_cfg();
        cyc(3);
        check(chan_enable[ch], 1'b1);
    endtask

    // masked and unmasked power-good falls, cleared by the status read
    task automatic t_fault();
        logic [31:0] q;
        wr(supmon_pkg::off_irq_stat, 32'h0000_000F);
        wr(supmon_pkg::off_irq_mask, 32'h0000_0002);
        fault_inj <= 3'b010;
        cyc(8);
        check(irq_wire, 1'b1);
        fault_inj <= 3'b011;
        cyc(8);
        check(irq_wire, 1'b0);
        cyc(4);
        check(irq_wire, 1'b0);
        rd(supmon_pkg::off_status, q);
        check(q[3:1], 3'b100);
        cyc(3);
        check(irq_wire, 1'b1);
        fault_inj <= 3'b000;
        wr(supmon_pkg::off_irq_mask, 32'h0000_0000);
        cfg_sh[0] = 1'b0;
        wr_cfg();
        cyc(3);
        check(chan_enable[0], 1'b0);
    endtask

    // heat kills running channels and refuses new enables
    task automatic t_hot();
        over_temp <= 1'b1;
        cyc(8);
        check(chan_enable, 3'b000);
        cfg_sh = 15'h0000;
        wr_cfg();
        cfg_sh = 15'h0421;
        wr_cfg();
        cyc(30);
        check(chan_enable, 3'b000);
        over_temp <= 1'b0;
        cyc(30);
        check(chan_enable, 3'b000);
    endtask

    // shutdown response: a supply drop drops channel 0, the only one running
    task automatic t_shutdown();
        logic [31:0] q;
        wr(supmon_pkg::off_ctrl, 32'h0000_0007);
        cfg_sh = 15'h0000;
        wr_cfg();
        cfg_sh = 15'h0001;
        wr_cfg();
        cyc(30);
        check(chan_enable[0], 1'b1);
        supply_below <= 1'b1;
        cyc(8);
        check(chan_enable, 3'b000);
        rd(supmon_pkg::off_status, q);
        check(q[0], 1'b1);
        supply_below <= 1'b0;
    endtask

    // hang guard, far beyond the longest expected run
    initial begin
        #400_000;
        mismatches++;
        print_verdict();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        supply_below = 1'b0;
        over_temp = 1'b0;
        fault_inj = 3'b000;
        cfg_sh = 15'h0000;
        cyc(8);
        hresetn <= 1'b1;
        t_reset();
        t_thresh();
        t_low_irq();
        t_chan(0, 3'h0);
        t_chan(1, 3'h1);
        t_chan(2, 3'h7);
        t_fault();
        t_hot();
        t_shutdown();
        print_verdict();
    end
endmodule // supply_monitor_fault_irq_ctrl_tb
`default_nettype wire
